// ===== rtl/csc_defines.vh
`ifndef CSC_DEFINES_VH
`define CSC_DEFINES_VH

// control status word fields
`define CSC_CPU_ID_HI 31
`define CSC_CPU_ID_LO 24
`define CSC_REV_ID_HI 23
`define CSC_REV_ID_LO 16
`define CSC_POWER_DOWN_SELECT_HI 15
`define CSC_POWER_DOWN_SELECT_LO 10
`define CSC_SAT_BIT 9
`define CSC_ENDIAN_BIT 8
`define CSC_PCC_HI 7
`define CSC_PCC_LO 5
`define CSC_DCC_HI 4
`define CSC_DCC_LO 2
`define CSC_SAVED_INTERRUPT_ENABLE_BIT 1
`define CSC_GIE_BIT 0

// power-down codes
`define CSC_PD_NONE 6'h00
`define CSC_PD1_ENABLED 6'h09
`define CSC_PD1_ANY 6'h11
`define CSC_PD2 6'h1a
`define CSC_PD3 6'h1c

// cache configuration fields
`define CSC_CC_PRIO_BIT 31
`define CSC_CC_PFLUSH_BIT 9
`define CSC_CC_DFLUSH_BIT 8
`define CSC_CC_L2_HI 2
`define CSC_CC_L2_LO 0

// reset values
`define CSC_RST_CACHE_CTRL 3'h0
`define CSC_RST_L2 3'h0
`define CSC_RST_SAT 1'h0
`define CSC_RST_ENDIAN 1'h1
`define CSC_RST_GIE 1'h0
`define CSC_RST_SAVED_INTERRUPT_ENABLE 1'h0
`define CSC_RST_PRIO 1'h0
`define CSC_RST_FLUSH 1'h0
`define CSC_RST_PULSE 1'h0
`define CSC_RST_WORD 32'h0000_0000

`endif

// ===== rtl/csc_regs.v
//
// Function
// - bits 31:16 read the fixed cpu identifier and silicon revision
// - power-down select field always reads back as zero
// - codes 001001 and 010001 enter sleep level one, interrupt wake
// - codes 011010 and 011100 enter levels two and three, reset wake
// - saturation flag set by units, only cleared by software
// - hardware set beats a same-cycle software clear
// - saturation flag updates one full cycle after the operation
// - false-condition instructions never touch the saturation flag
// - bit 8 reads the byte order, little-endian by default
// - program cache field accepts 000 or 010, others reserved
// - data cache field accepts 000 or 010, others reserved
// - taking an interrupt saves global enable into saved enable
// - global enable gates maskable interrupts only, resets to 0
// - priority bit gives transfer switch precedence over data cache
// - cache config bits 9:8 write-only, 30:10 undefined, 7:3 zero
// - writing 1 to bit 9 invalidates the program cache
// - writing 1 to bit 8 invalidates the data cache
// - level2 partition field selects cache ways versus sram
//
`timescale 1ns/1ps
`default_nettype none
`include "csc_defines.vh"

module csc_regs #(
    // arbitrary neutral identity values
    parameter [7:0] CPU_ID = 8'h5a,
    parameter [7:0] REV_ID = 8'h01,
    parameter N_UNITS = 8
) (
    input wire ref_clk,
    input wire rstn,
    // move-control access: 0 selects control status, 1 cache configuration
    input wire move_wr,
    input wire move_rd,
    input wire move_sel,
    input wire [31:0] move_wdata,
    output wire [31:0] move_rdata,
    // saturation reports, one bit per functional unit
    input wire [N_UNITS-1:0] unit_saturate,
    input wire [N_UNITS-1:0] unit_cond_true,
    // interrupt and strap inputs
    input wire interrupt_taken,
    input wire little_endian_strap,
    input wire maskable_irq_req,
    // outputs to surrounding logic
    output wire maskable_irq_gated,
    output wire [5:0] power_down_req,
    output wire power_down_strobe,
    output wire [2:0] program_cache_ctrl,
    output wire [2:0] data_cache_ctrl,
    output wire global_interrupt_enable,
    output wire saved_interrupt_enable,
    output wire transfer_switch_priority,
    output wire program_cache_flush,
    output wire data_cache_flush,
    output wire [2:0] level2_partition
);

    // ----------------------------------------
    // decode helpers
    // ----------------------------------------
    function pd_valid;
        input [5:0] code;
        begin
            pd_valid = (code == `CSC_PD1_ENABLED) || (code == `CSC_PD1_ANY) ||
                       (code == `CSC_PD2) || (code == `CSC_PD3);
        end
    endfunction

    function cache_mode_ok;
        input [2:0] mode;
        begin
            cache_mode_ok = (mode == 3'h0) || (mode == 3'h2);
        end
    endfunction

    function l2_mode_ok;
        input [2:0] mode;
        begin
            l2_mode_ok = (mode <= 3'h3) || (mode == 3'h7);
        end
    endfunction

    wire wr_csw = move_wr && !move_sel;
    wire wr_cache_configuration = move_wr && move_sel;
    wire [5:0] pd_code = move_wdata[`CSC_POWER_DOWN_SELECT_HI:`CSC_POWER_DOWN_SELECT_LO];
    wire [2:0] pcc_in = move_wdata[`CSC_PCC_HI:`CSC_PCC_LO];
    wire [2:0] dcc_in = move_wdata[`CSC_DCC_HI:`CSC_DCC_LO];
    wire [2:0] l2_in = move_wdata[`CSC_CC_L2_HI:`CSC_CC_L2_LO];

    // ----------------------------------------
    // register state
    // ----------------------------------------
    reg sat_pend_q;
    reg sat_pend_d;
    reg saturation_flag_q;
    reg saturation_flag_d;
    reg endian_q;
    reg endian_d;
    reg strap_taken_q;
    reg strap_taken_d;
    reg [2:0] program_cache_ctrl_q;
    reg [2:0] program_cache_ctrl_d;
    reg [2:0] data_cache_ctrl_q;
    reg [2:0] data_cache_ctrl_d;
    reg global_interrupt_enable_q;
    reg global_interrupt_enable_d;
    reg saved_interrupt_enable_q;
    reg saved_interrupt_enable_d;
    reg [5:0] power_down_req_q;
    reg [5:0] power_down_req_d;
    reg power_down_strobe_q;
    reg power_down_strobe_d;
    reg maskable_irq_gated_q;
    reg maskable_irq_gated_d;
    reg transfer_switch_priority_q;
    reg transfer_switch_priority_d;
    reg program_cache_flush_q;
    reg program_cache_flush_d;
    reg data_cache_flush_q;
    reg data_cache_flush_d;
    reg [2:0] level2_partition_q;
    reg [2:0] level2_partition_d;
    reg [31:0] move_rdata_q;
    reg [31:0] move_rdata_d;

    // outputs are bare flops, no logic between register and pin
    assign move_rdata = move_rdata_q;
    assign maskable_irq_gated = maskable_irq_gated_q;
    assign power_down_req = power_down_req_q;
    assign power_down_strobe = power_down_strobe_q;
    assign program_cache_ctrl = program_cache_ctrl_q;
    assign data_cache_ctrl = data_cache_ctrl_q;
    assign global_interrupt_enable = global_interrupt_enable_q;
    assign saved_interrupt_enable = saved_interrupt_enable_q;
    assign transfer_switch_priority = transfer_switch_priority_q;
    assign program_cache_flush = program_cache_flush_q;
    assign data_cache_flush = data_cache_flush_q;
    assign level2_partition = level2_partition_q;

    // ----------------------------------------
    // saturation flag
    // ----------------------------------------
    // false condition masked per unit
    wire [N_UNITS-1:0] unit_sat_live;
    genvar gi;
    generate
        for (gi = 0; gi < N_UNITS; gi = gi + 1) begin : g_unit
            assign unit_sat_live[gi] = unit_saturate[gi] && unit_cond_true[gi];
        end
    endgenerate
    wire sat_event = |unit_sat_live;

    always @* begin
        sat_pend_d = sat_event;
    end

    // set by units, cleared by write of 0
    // set wins over clear
    // a clear racing a pending set must not hide the saturation
    always @* begin
        saturation_flag_d = saturation_flag_q;
        if (sat_pend_q) begin
            saturation_flag_d = 1'h1;
        end else if (wr_csw && !move_wdata[`CSC_SAT_BIT]) begin
            saturation_flag_d = 1'h0;
        end
    end

    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sat_pend_q <= `CSC_RST_SAT;
            saturation_flag_q <= `CSC_RST_SAT;
        end else begin
            sat_pend_q <= sat_pend_d;
            saturation_flag_q <= saturation_flag_d;
        end
    end

    // ----------------------------------------
    // endian capture
    // ----------------------------------------
    // strap caught after reset release, not in the reset branch
    // byte order indicator
    always @* begin
        endian_d = endian_q;
        strap_taken_d = strap_taken_q;
        if (!strap_taken_q) begin
            endian_d = little_endian_strap;
            strap_taken_d = 1'h1;
        end
    end

    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            endian_q <= `CSC_RST_ENDIAN;
            strap_taken_q <= `CSC_RST_PULSE;
        end else begin
            endian_q <= endian_d;
            strap_taken_q <= strap_taken_d;
        end
    end

    // ----------------------------------------
    // control status word
    // ----------------------------------------
    always @* begin
        program_cache_ctrl_d = program_cache_ctrl_q;
        data_cache_ctrl_d = data_cache_ctrl_q;
        power_down_req_d = power_down_req_q;
        power_down_strobe_d = 1'h0;
        if (wr_csw) begin
            if (cache_mode_ok(pcc_in)) begin
                program_cache_ctrl_d = pcc_in;
            end
            if (cache_mode_ok(dcc_in)) begin
                data_cache_ctrl_d = dcc_in;
            end
            // only valid sleep codes reach controller
            if (pd_valid(pd_code)) begin
                power_down_req_d = pd_code;
                power_down_strobe_d = 1'h1;
            end
        end
    end

    // save enable on interrupt entry; hardware wins
    always @* begin
        saved_interrupt_enable_d = saved_interrupt_enable_q;
        global_interrupt_enable_d = global_interrupt_enable_q;
        if (interrupt_taken) begin
            saved_interrupt_enable_d = global_interrupt_enable_q;
            global_interrupt_enable_d = 1'h0;
        end else if (wr_csw) begin
            saved_interrupt_enable_d = move_wdata[`CSC_SAVED_INTERRUPT_ENABLE_BIT];
            global_interrupt_enable_d = move_wdata[`CSC_GIE_BIT];
        end
    end

    // maskable interrupts gated by global enable
    always @* begin
        maskable_irq_gated_d = maskable_irq_req && global_interrupt_enable_q;
    end

    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            program_cache_ctrl_q <= `CSC_RST_CACHE_CTRL;
            data_cache_ctrl_q <= `CSC_RST_CACHE_CTRL;
            global_interrupt_enable_q <= `CSC_RST_GIE;
            saved_interrupt_enable_q <= `CSC_RST_SAVED_INTERRUPT_ENABLE;
            power_down_req_q <= `CSC_PD_NONE;
            power_down_strobe_q <= `CSC_RST_PULSE;
            maskable_irq_gated_q <= `CSC_RST_PULSE;
        end else begin
            program_cache_ctrl_q <= program_cache_ctrl_d;
            data_cache_ctrl_q <= data_cache_ctrl_d;
            global_interrupt_enable_q <= global_interrupt_enable_d;
            saved_interrupt_enable_q <= saved_interrupt_enable_d;
            power_down_req_q <= power_down_req_d;
            power_down_strobe_q <= power_down_strobe_d;
            maskable_irq_gated_q <= maskable_irq_gated_d;
        end
    end

    // ----------------------------------------
    // cache configuration
    // ----------------------------------------
    always @* begin
        transfer_switch_priority_d = transfer_switch_priority_q;
        level2_partition_d = level2_partition_q;
        program_cache_flush_d = wr_cache_configuration && move_wdata[`CSC_CC_PFLUSH_BIT];
        data_cache_flush_d = wr_cache_configuration && move_wdata[`CSC_CC_DFLUSH_BIT];
        if (wr_cache_configuration) begin
            transfer_switch_priority_d = move_wdata[`CSC_CC_PRIO_BIT];
            if (l2_mode_ok(l2_in)) begin
                level2_partition_d = l2_in;
            end
        end
    end

    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            transfer_switch_priority_q <= `CSC_RST_PRIO;
            program_cache_flush_q <= `CSC_RST_FLUSH;
            data_cache_flush_q <= `CSC_RST_FLUSH;
            level2_partition_q <= `CSC_RST_L2;
        end else begin
            transfer_switch_priority_q <= transfer_switch_priority_d;
            program_cache_flush_q <= program_cache_flush_d;
            data_cache_flush_q <= data_cache_flush_d;
            level2_partition_q <= level2_partition_d;
        end
    end

    // ----------------------------------------
    // read path
    // ----------------------------------------
    // registered read data, one cycle after the read strobe
    // flush bits are pulses only, so nothing is stored to read back
    always @* begin
        move_rdata_d = move_rdata_q;
        if (move_rd) begin
            move_rdata_d = 32'h0000_0000;
            if (!move_sel) begin
                move_rdata_d[`CSC_CPU_ID_HI:`CSC_CPU_ID_LO] = CPU_ID;
                move_rdata_d[`CSC_REV_ID_HI:`CSC_REV_ID_LO] = REV_ID;
                move_rdata_d[`CSC_SAT_BIT] = saturation_flag_q;
                move_rdata_d[`CSC_ENDIAN_BIT] = endian_q;
                move_rdata_d[`CSC_PCC_HI:`CSC_PCC_LO] = program_cache_ctrl_q;
                move_rdata_d[`CSC_DCC_HI:`CSC_DCC_LO] = data_cache_ctrl_q;
                move_rdata_d[`CSC_SAVED_INTERRUPT_ENABLE_BIT] = saved_interrupt_enable_q;
                move_rdata_d[`CSC_GIE_BIT] = global_interrupt_enable_q;
            end else begin
                // write-only and reserved bits read zero
                move_rdata_d[`CSC_CC_PRIO_BIT] = transfer_switch_priority_q;
                move_rdata_d[`CSC_CC_L2_HI:`CSC_CC_L2_LO] = level2_partition_q;
            end
        end
    end

    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            move_rdata_q <= `CSC_RST_WORD;
        end else begin
            move_rdata_q <= move_rdata_d;
        end
    end

endmodule // csc_regs

`default_nettype wire

// ===== tb/csc_regs_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module csc_regs_asserts #(parameter N_UNITS = 8) (
    input wire logic ref_clk, rstn, move_wr, move_rd, move_sel, interrupt_taken,
    input wire logic [31:0] move_wdata, move_rdata,
    input wire logic [N_UNITS-1:0] unit_saturate, unit_cond_true,
    input wire logic [5:0] power_down_req,
    input wire logic power_down_strobe, global_interrupt_enable, saved_interrupt_enable,
    input wire logic transfer_switch_priority, program_cache_flush, data_cache_flush,
    input wire logic [2:0] level2_partition
);
    // ---
    // register checks
    // ---
    logic w0, w1, pv;
    assign w0 = move_wr & ~move_sel;
    assign w1 = move_wr & move_sel;
    assign pv = move_wdata[15:10] inside {6'h09, 6'h11, 6'h1a, 6'h1c};
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    property p_id; move_rd && !move_sel |=> move_rdata[31:10] == {16'h5a01, 6'h00}; endproperty
    a_id: assert property (p_id) else $error("id readback wrong");
    // flag is only seen through reads, two edges after the event
    property p_sat; |(unit_saturate & unit_cond_true) ##2 (move_rd && !move_sel)
        |=> move_rdata[9]; endproperty
    a_sat: assert property (p_sat) else $error("saturation flag missing");
    property p_gie; w0 && !interrupt_taken
        |=> {saved_interrupt_enable, global_interrupt_enable} == $past(move_wdata[1:0]);
    endproperty
    a_gie: assert property (p_gie) else $error("enable write lost");
    property p_int; interrupt_taken
        |=> saved_interrupt_enable == $past(global_interrupt_enable) && !global_interrupt_enable;
    endproperty
    a_int: assert property (p_int) else $error("enable not saved");
    property p_pd; w0 && pv |=> power_down_strobe && power_down_req == $past(move_wdata[15:10]);
    endproperty
    a_pd: assert property (p_pd) else $error("sleep request missing");
    property p_pdr; w0 && !pv |=> !power_down_strobe && $stable(power_down_req); endproperty
    a_pdr: assert property (p_pdr) else $error("reserved sleep code taken");
    property p_cf; w1 |=> {transfer_switch_priority, program_cache_flush, data_cache_flush}
        == {$past(move_wdata[31]), $past(move_wdata[9:8])}; endproperty
    a_cf: assert property (p_cf) else $error("priority or flush wrong");
    property p_l2; w1 && move_wdata[2] && move_wdata[1:0] != 2'h3
        |=> $stable(level2_partition); endproperty
    a_l2: assert property (p_l2) else $error("reserved partition taken");
endmodule // csc_regs_asserts
bind csc_regs csc_regs_asserts #(.N_UNITS(N_UNITS)) u_chk (.ref_clk, .rstn, .move_wr, .move_rd,
    .move_sel, .interrupt_taken, .move_wdata, .move_rdata, .unit_saturate, .unit_cond_true,
    .power_down_req, .power_down_strobe, .global_interrupt_enable, .saved_interrupt_enable,
    .transfer_switch_priority, .program_cache_flush, .data_cache_flush, .level2_partition);
`default_nettype wire

// ===== tb/csc_unit_model.sv
`timescale 1ns/1ps
`default_nettype none
module csc_unit_model (
    input wire logic ref_clk,
    output logic [7:0] unit_saturate,
    output logic [7:0] unit_cond_true
);
    // idle units show every condition true, so only the pulse decides
    initial begin
        unit_saturate = 8'h00;
        unit_cond_true = 8'hff;
    end
    task saturation_flag(input logic [7:0] u, input logic [7:0] c);
        unit_saturate = u;
        unit_cond_true = c;
        @(posedge ref_clk);
        #1 unit_saturate = 8'h00;
        unit_cond_true = 8'hff;
    endtask
endmodule // csc_unit_model
`default_nettype wire

// ===== tb/csc_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module csc_regs_tb;
    typedef struct {logic sel; logic [31:0] wd; logic [31:0] exp;} csc_row_t;
    logic ref_clk = 1'h0, rstn = 1'h0, move_wr = 1'h0, move_rd = 1'h0, move_sel = 1'h0;
    logic interrupt_taken = 1'h0, maskable_irq_req = 1'h0, little_endian_strap = 1'h1;
    logic [31:0] move_wdata = 32'h0, move_rdata, rd_q;
    logic [7:0] unit_saturate, unit_cond_true;
    logic [5:0] power_down_req, pd_exp;
    logic [2:0] program_cache_ctrl, data_cache_ctrl, level2_partition;
    logic maskable_irq_gated, power_down_strobe, global_interrupt_enable, saved_interrupt_enable;
    logic transfer_switch_priority, program_cache_flush, data_cache_flush;
    int num_errors = 0;
    int checks_done = 0;
    logic [5:0] pd_c [6] = '{6'h09, 6'h11, 6'h1a, 6'h1c, 6'h2a, 6'h00};
    csc_row_t rows [7] = '{'{1'h0, 32'hffffffff, 32'h5a010103}, '{1'h0, 32'h2448, 32'h5a010148},
        '{1'h0, 32'h60, 32'h5a010140}, '{1'h1, 32'hffffffff, 32'h80000007},
        '{1'h1, 32'h6, 32'h7}, '{1'h1, 32'h302, 32'h2}, '{1'h1, 32'h1, 32'h1}};
    always #4 ref_clk = ~ref_clk;
    csc_regs uut (.ref_clk, .rstn, .move_wr, .move_rd, .move_sel, .move_wdata, .move_rdata,
        .unit_saturate, .unit_cond_true, .interrupt_taken, .little_endian_strap,
        .maskable_irq_req, .maskable_irq_gated, .power_down_req, .power_down_strobe,
        .program_cache_ctrl, .data_cache_ctrl, .global_interrupt_enable, .saved_interrupt_enable,
        .transfer_switch_priority, .program_cache_flush, .data_cache_flush, .level2_partition);
    csc_unit_model u_units (.ref_clk, .unit_saturate, .unit_cond_true);
    task tick;
        @(posedge ref_clk);
        #1;
    endtask
    // idle cycle after each access keeps strobes from being rewritten in one step
    task wr(input logic s, input logic [31:0] d);
        move_wr = 1'h1;
        move_sel = s;
        move_wdata = d;
        tick;
        move_wr = 1'h0;
        tick;
    endtask
    task rd(input logic s);
        move_rd = 1'h1;
        move_sel = s;
        tick;
        move_rd = 1'h0;
        rd_q = move_rdata;
        tick;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task complete_run;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge ref_clk);
        #1 rstn = 1'h1;
        foreach (rows[i]) begin
            wr(rows[i].sel, rows[i].wd);
            rd(rows[i].sel);
            chk(rd_q, rows[i].exp);
        end
        chk({26'h0, program_cache_ctrl, data_cache_ctrl}, 32'h10);
        foreach (pd_c[i]) begin
            wr(1'h0, {16'h0, pd_c[i], 10'h0});
            if (i < 4) pd_exp = pd_c[i];
            chk({26'h0, power_down_req}, {26'h0, pd_exp});
        end
        u_units.saturation_flag(8'h04, 8'hfb);
        repeat (2) tick;
        rd(1'h0);
        chk({31'h0, rd_q[9]}, 32'h0);
        u_units.saturation_flag(8'h81, 8'h81);
        tick;
        rd(1'h0);
        chk({31'h0, rd_q[9]}, 32'h1);
        wr(1'h0, 32'h0);
        rd(1'h0);
        chk({31'h0, rd_q[9]}, 32'h0);
        fork
            u_units.saturation_flag(8'h10, 8'h10);
            begin
                tick;
                wr(1'h0, 32'h0);
            end
        join
        rd(1'h0);
        chk({31'h0, rd_q[9]}, 32'h1);
        wr(1'h0, 32'h1);
        maskable_irq_req = 1'h1;
        repeat (2) tick;
        chk({31'h0, maskable_irq_gated}, 32'h1);
        interrupt_taken = 1'h1;
        tick;
        interrupt_taken = 1'h0;
        chk({30'h0, saved_interrupt_enable, global_interrupt_enable}, 32'h2);
        repeat (2) tick;
        chk({31'h0, maskable_irq_gated}, 32'h0);
        // second reset with the strap flipped, so the capture is really seen
        rstn = 1'h0;
        little_endian_strap = 1'h0;
        tick;
        chk({10'h0, program_cache_ctrl, data_cache_ctrl, power_down_req, level2_partition,
            transfer_switch_priority, global_interrupt_enable, saved_interrupt_enable,
            maskable_irq_gated, power_down_strobe, program_cache_flush,
            data_cache_flush}, 32'h0);
        rstn = 1'h1;
        tick;
        rd(1'h0);
        chk(rd_q, 32'h5a010000);
        rd(1'h1);
        chk(rd_q, 32'h0);
        complete_run;
    end
    initial begin
        #100000;
        num_errors++;
        complete_run;
    end
endmodule // csc_regs_tb
`default_nettype wire
